// ==== plbk_top.sv ====
/*
 * PLL soft/hard offset-limit alarms and a leaky-bucket inactivity alarm
 * with its register bank. Assumes a plain register port on ref_clk; PLL
 * offsets arrive as synchronous 2's complement words in 0.628 ppm units,
 * the input fault flag is asynchronous.
 */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module plbk_top
	import plbk_pkg::*;
#(
	parameter int unsigned CYCLE_CLKS = BUCKET_CYCLES
) (
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire plbk_pkg::plbk_req_t req,
	output logic [7:0]               rdata,
	input  wire logic signed [7:0]   pll0_offset,
	input  wire logic signed [7:0]   pll1_offset,
	input  wire logic                pll0_phase_lost_raw,
	input  wire logic                pll1_phase_lost_raw,
	input  wire logic                ref_fault_async,
	output logic [7:0]               soft_status,
	output plbk_pkg::plbk_pll_flags_t pll_flags,
	output logic                     inactivity_alarm,
	output logic                     irq
);
	import plbk_pkg::*;

	// Checked at elaboration: the bucket timer needs two clocks per cycle at least
	if (CYCLE_CLKS < 2) begin : g_cycle_check
		$error("CYCLE_CLKS must be at least 2");
	end

	typedef enum logic [1:0] {
		PLBK_IDLE  = 2'b00,
		PLBK_ALARM = 2'b01
	} plbk_state_t;

	// Absolute value of an offset word, returned unsigned in 8 bits so -128 fits
	function automatic logic [7:0] plbk_abs(input logic signed [7:0] v);
		plbk_abs = v[7] ? 8'((~v) + 8'h01) : 8'(v);
	endfunction

	logic [7:0]      soft_q;
	logic [7:0]      soft_d;
	logic [7:0]      raise_q;
	logic [7:0]      raise_d;
	logic [7:0]      lower_q;
	logic [7:0]      lower_d;
	logic [7:0]      size_q;
	logic [7:0]      size_d;
	logic [7:0]      decay_q;
	logic [7:0]      decay_d;
	logic [7:0]      hard_q;
	logic [7:0]      hard_d;
	logic [7:0]      stat_q;
	logic [7:0]      stat_d;
	logic [7:0]      mask_q;
	logic [7:0]      mask_d;
	logic [7:0]      rdata_q;
	logic [7:0]      rdata_d;
	logic [7:0]      level_q;
	logic [7:0]      level_d;
	logic [3:0]      quiet_q;
	logic [3:0]      quiet_d;
	logic [31:0]     tick_q;
	logic [31:0]     tick_d;
	logic            fault_seen_q;
	logic            fault_seen_d;
	logic            sync1_q;
	logic            sync2_q;
	plbk_state_t     st_q;
	plbk_state_t     st_d;
	logic            alarm_q;
	logic            alarm_d;
	logic            irq_q;
	logic            irq_d;
	logic [7:0]      soft_status_q;
	logic [7:0]      soft_status_d;
	plbk_pll_flags_t flags_q;
	plbk_pll_flags_t flags_d;

	logic            cycle_end;
	logic [7:0]      abs0;
	logic [7:0]      abs1;
	logic [7:0]      soft_lim;
	logic            over0;
	logic            over1;
	logic            hard0;
	logic            hard1;
	logic [3:0]      decay_period;
	logic [7:0]      ev;

	// Two-flop synchroniser; only sync2_q is read by logic
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= ref_fault_async;
			sync2_q <= sync1_q;
		end
	end

	always_comb begin
		abs0      = plbk_abs(pll0_offset);
		abs1      = plbk_abs(pll1_offset);
		soft_lim  = {1'b0, soft_q[6:0]};
		over0     = abs0 > soft_lim;
		over1     = abs1 > soft_lim;
		hard0     = abs0 >= hard_q;
		hard1     = abs1 >= hard_q;
		cycle_end = tick_q == 32'(CYCLE_CLKS - 1);
		case (decay_q[1:0])
			2'd0:    decay_period = 4'd1;
			2'd1:    decay_period = 4'd2;
			2'd2:    decay_period = 4'd4;
			default: decay_period = 4'd8;
		endcase
	end

	// Bucket cycle timer and accumulator
	always_comb begin
		tick_d       = cycle_end ? 32'h0 : tick_q + 32'h1;
		fault_seen_d = fault_seen_q | sync2_q;
		level_d      = level_q;
		quiet_d      = quiet_q;
		if (cycle_end) begin
			fault_seen_d = sync2_q;
			if (fault_seen_q || sync2_q) begin
				quiet_d = 4'h0;
				if (level_q < size_q)
					level_d = level_q + 8'h01;
			end else if (quiet_q + 4'h1 >= decay_period) begin
				quiet_d = 4'h0;
				if (level_q != 8'h00)
					level_d = level_q - 8'h01;
			end else begin
				quiet_d = quiet_q + 4'h1;
			end
		end
		// Shrinking the bucket clips the stored count at once
		if (level_d > size_q)
			level_d = size_q;
	end

	// Alarm hysteresis: raise at upper, clear at lower
	always_comb begin
		st_d = st_q;
		case (st_q)
			PLBK_IDLE:  if (level_q >= raise_q) st_d = PLBK_ALARM;
			PLBK_ALARM: if (level_q <= lower_q) st_d = PLBK_IDLE;
			default:    st_d = PLBK_IDLE;
		endcase
		alarm_d = (st_d == PLBK_ALARM);
	end

	// Register bank, sticky status with set winning over write-one clear
	always_comb begin
		soft_d  = soft_q;
		raise_d = raise_q;
		lower_d = lower_q;
		size_d  = size_q;
		decay_d = decay_q;
		hard_d  = hard_q;
		mask_d  = mask_q;
		rdata_d = 8'h00;
		ev      = 8'h00;
		ev[ST_SOFT0]     = over0;
		ev[ST_SOFT1]     = over1;
		ev[ST_PHLOST0]   = flags_d.phase_lost0;
		ev[ST_PHLOST1]   = flags_d.phase_lost1;
		ev[ST_ALM_RAISE] = (st_q == PLBK_IDLE) && (st_d == PLBK_ALARM);
		ev[ST_ALM_CLEAR] = (st_q == PLBK_ALARM) && (st_d == PLBK_IDLE);
		stat_d  = stat_q;
		if (req.wr) begin
			case (req.addr)
				ADDR_SOFT_LIMIT:  soft_d  = req.wdata;
				ADDR_RAISE_THR:   raise_d = req.wdata;
				ADDR_LOWER_THR:   lower_d = req.wdata;
				ADDR_BUCKET_SIZE: size_d  = req.wdata;
				ADDR_DECAY_RATE:  decay_d = {6'h00, req.wdata[1:0]};
				ADDR_HARD_LIMIT:  hard_d  = req.wdata;
				ADDR_STATUS:      stat_d  = stat_q & ~req.wdata;
				ADDR_MASK:        mask_d  = {2'h0, req.wdata[5:0]};
				default:          ;
			endcase
		end
		stat_d = stat_d | ev;
		if (req.rd) begin
			case (req.addr)
				ADDR_SOFT_LIMIT:  rdata_d = soft_q;
				ADDR_RAISE_THR:   rdata_d = raise_q;
				ADDR_LOWER_THR:   rdata_d = lower_q;
				ADDR_BUCKET_SIZE: rdata_d = size_q;
				ADDR_DECAY_RATE:  rdata_d = decay_q;
				ADDR_HARD_LIMIT:  rdata_d = hard_q;
				ADDR_STATUS:      rdata_d = stat_q;
				ADDR_MASK:        rdata_d = mask_q;
				ADDR_BUCKET_LVL:  rdata_d = level_q;
				default:          rdata_d = 8'h00;
			endcase
		end
		irq_d = |(stat_d & mask_d);
	end

	// PLL flags: soft alarm only flags, hard-limit option forces phase-lost
	always_comb begin
		soft_status_d = 8'h00;
		soft_status_d[SOFT_ALM0_BIT] = over0;
		soft_status_d[SOFT_ALM1_BIT] = over1;
		flags_d.soft_alarm0 = over0;
		flags_d.soft_alarm1 = over1;
		flags_d.phase_lost0 = pll0_phase_lost_raw |
			(soft_q[PHLOSS_EN_BIT] & hard0);
		flags_d.phase_lost1 = pll1_phase_lost_raw |
			(soft_q[PHLOSS_EN_BIT] & hard1);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			soft_q        <= RST_SOFT_LIMIT;
			raise_q       <= RST_RAISE_THR;
			lower_q       <= RST_LOWER_THR;
			size_q        <= RST_BUCKET_SIZE;
			decay_q       <= RST_DECAY_RATE;
			hard_q        <= RST_HARD_LIMIT;
			mask_q        <= RST_MASK;
			stat_q        <= 8'h00;
			rdata_q       <= 8'h00;
			level_q       <= 8'h00;
			quiet_q       <= 4'h0;
			tick_q        <= 32'h0;
			fault_seen_q  <= 1'b0;
			st_q          <= PLBK_IDLE;
			alarm_q       <= 1'b0;
			irq_q         <= 1'b0;
			soft_status_q <= 8'h00;
			flags_q       <= '0;
		end else begin
			soft_q        <= soft_d;
			raise_q       <= raise_d;
			lower_q       <= lower_d;
			size_q        <= size_d;
			decay_q       <= decay_d;
			hard_q        <= hard_d;
			mask_q        <= mask_d;
			stat_q        <= stat_d;
			rdata_q       <= rdata_d;
			level_q       <= level_d;
			quiet_q       <= quiet_d;
			tick_q        <= tick_d;
			fault_seen_q  <= fault_seen_d;
			st_q          <= st_d;
			alarm_q       <= alarm_d;
			irq_q         <= irq_d;
			soft_status_q <= soft_status_d;
			flags_q       <= flags_d;
		end
	end

	assign rdata            = rdata_q;
	assign soft_status      = soft_status_q;
	assign pll_flags        = flags_q;
	// Own flop rather than a state decode, so the pin cannot glitch
	assign inactivity_alarm = alarm_q;
	assign irq              = irq_q;

	sequence s_hard0;
		soft_q[PHLOSS_EN_BIT] && hard0;
	endsequence

	AST_HARD_ENABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_hard0 |=> flags_q.phase_lost0)
		else $error("hard limit did not force phase lost on pll0");
	AST_HARD_PLL1: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(soft_q[PHLOSS_EN_BIT] && hard1) |=> flags_q.phase_lost1)
		else $error("hard limit did not force phase lost on pll1");
	AST_NO_FORCE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!soft_q[PHLOSS_EN_BIT] && !pll0_phase_lost_raw) |=> !flags_q.phase_lost0)
		else $error("phase lost raised with option off");
	AST_SOFT_SYM: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(plbk_abs(pll0_offset) > {1'b0, soft_q[6:0]}) |=> soft_status_q[SOFT_ALM0_BIT])
		else $error("soft limit not symmetric");
	AST_SOFT_BITS: assert property (@(posedge ref_clk) disable iff (!reset_n)
		soft_status_q[SOFT_ALM1_BIT] == $past(over1) && soft_status_q[3:0] == 4'h0)
		else $error("soft alarm bits wrong");
	AST_INC: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(cycle_end && sync2_q && level_q < size_q && !req.wr) |=> level_q == $past(level_q) + 8'h01)
		else $error("bucket failed to increment");
	AST_DEC_SLOW: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!cycle_end && !req.wr) |=> level_q == $past(level_q) || level_q == size_q)
		else $error("bucket moved outside a cycle end");
	AST_RAISE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(st_q == PLBK_IDLE && level_q >= raise_q) |=> inactivity_alarm)
		else $error("alarm not raised at threshold");
	AST_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(st_q == PLBK_ALARM && level_q <= lower_q) |=> !inactivity_alarm)
		else $error("alarm not cleared at lower threshold");
	AST_SIZE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$stable(size_q) |-> level_q <= size_q)
		else $error("bucket above size");
	AST_FLOOR: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(level_q == 8'h00 && !sync2_q && !fault_seen_q) |=> level_q == 8'h00)
		else $error("bucket went below zero");

	// Offset beyond the soft limit lands in the sticky status, set winning over a clear
	sequence s_pll0_over;
		over0;
	endsequence

	// A fault on the pin reaches the bucket two clocks later, through the synchroniser
	sequence s_fault_at_end;
		ref_fault_async ##2 (cycle_end && level_q < size_q && !req.wr);
	endsequence

	sequence s_quiet_end;
		cycle_end && !sync2_q && !fault_seen_q && decay_q[1:0] == 2'd0 &&
			level_q != 8'h00 && level_q <= size_q && !req.wr;
	endsequence

	AST_SOFT_PLL0: assert property (@(posedge ref_clk) disable iff (!reset_n)
		soft_status_q[SOFT_ALM0_BIT] == $past(over0) && soft_status_q[7:6] == 2'h0)
		else $error("soft alarm bit for pll0 wrong");
	AST_STICKY_SOFT: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_pll0_over |=> stat_q[ST_SOFT0])
		else $error("soft alarm event not held in status");
	AST_STICKY_HARD: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(soft_q[PHLOSS_EN_BIT] && hard1) |=> stat_q[ST_PHLOST1])
		else $error("hard limit phase lost not held in status");
	AST_SYNC_INC: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_fault_at_end |=> level_q == $past(level_q) + 8'h01)
		else $error("pin fault did not raise the bucket");
	AST_QUIET_DEC: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_quiet_end |=> level_q == $past(level_q) - 8'h01)
		else $error("bucket did not drain after a quiet cycle");
	AST_IDLE_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!inactivity_alarm && level_q < raise_q) |=> !inactivity_alarm)
		else $error("alarm raised below threshold");
	AST_ALARM_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(inactivity_alarm && level_q > lower_q) |=> inactivity_alarm)
		else $error("alarm cleared above lower threshold");
endmodule // plbk_top

// ==== plbk_pkg.sv ====
/*
 * Package for the PLL offset-limit and leaky-bucket alarm block: register
 * indices, reset values, field positions, timing counts and carrier types.
 * Assumes a single 20 MHz reference clock.
 */
package plbk_pkg;
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned BUCKET_CYCLE_MS = 128;
	localparam int unsigned BUCKET_CYCLES   = (CLK_HZ / 1000) * BUCKET_CYCLE_MS;

	localparam logic [7:0] ADDR_SOFT_LIMIT  = 8'h4D;
	localparam logic [7:0] ADDR_RAISE_THR   = 8'h4E;
	localparam logic [7:0] ADDR_LOWER_THR   = 8'h51;
	localparam logic [7:0] ADDR_BUCKET_SIZE = 8'h52;
	localparam logic [7:0] ADDR_DECAY_RATE  = 8'h53;
	localparam logic [7:0] ADDR_HARD_LIMIT  = 8'h41;
	localparam logic [7:0] ADDR_STATUS      = 8'h60;
	localparam logic [7:0] ADDR_MASK        = 8'h61;
	localparam logic [7:0] ADDR_BUCKET_LVL  = 8'h62;

	localparam logic [7:0] RST_SOFT_LIMIT  = 8'h8E;
	localparam logic [7:0] RST_RAISE_THR   = 8'h06;
	localparam logic [7:0] RST_LOWER_THR   = 8'h04;
	localparam logic [7:0] RST_BUCKET_SIZE = 8'h08;
	localparam logic [7:0] RST_DECAY_RATE  = 8'h00;
	localparam logic [7:0] RST_HARD_LIMIT  = 8'h7F;
	localparam logic [7:0] RST_MASK        = 8'h00;

	localparam int unsigned PHLOSS_EN_BIT = 7;
	localparam int unsigned SOFT_ALM0_BIT = 4;
	localparam int unsigned SOFT_ALM1_BIT = 5;
	localparam int unsigned ST_SOFT0      = 0;
	localparam int unsigned ST_SOFT1      = 1;
	localparam int unsigned ST_PHLOST0    = 2;
	localparam int unsigned ST_PHLOST1    = 3;
	localparam int unsigned ST_ALM_RAISE  = 4;
	localparam int unsigned ST_ALM_CLEAR  = 5;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} plbk_req_t;

	typedef struct packed {
		logic       soft_alarm0;
		logic       soft_alarm1;
		logic       phase_lost0;
		logic       phase_lost1;
	} plbk_pll_flags_t;
endpackage

// ==== plbk_tb.sv ====
/*
 * Self-checking bench for plbk_top: register defaults, soft and hard
 * offset limits, leaky-bucket counting and the interrupt path.
 * Assumes a short bucket cycle through CYCLE_CLKS and a 20 MHz ref_clk.
 */
`timescale 1ns/1ps
module testbench;
	import plbk_pkg::*;
	localparam int CYC = 20;
	logic                      ref_clk;
	logic                      reset_n;
	plbk_pkg::plbk_req_t       req;
	logic [7:0]                rdata;
	logic signed [7:0]         off0;
	logic signed [7:0]         off1;
	logic                      raw0;
	logic                      raw1;
	logic                      fault;
	logic [7:0]                soft_status;
	plbk_pkg::plbk_pll_flags_t pll_flags;
	logic                      inactivity_alarm;
	logic                      irq;
	int                        err_count;
	int                        checks;
	logic [31:0]               lfsr_q;
	logic [7:0]                v;
	int                        t0;
	int                        dt;

	plbk_top #(.CYCLE_CLKS(CYC)) plbk_top_inst (
		.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .rdata(rdata),
		.pll0_offset(off0), .pll1_offset(off1), .pll0_phase_lost_raw(raw0),
		.pll1_phase_lost_raw(raw1), .ref_fault_async(fault), .soft_status(soft_status),
		.pll_flags(pll_flags), .inactivity_alarm(inactivity_alarm), .irq(irq));

	always #25 ref_clk = ~ref_clk;

	function automatic logic [31:0] lfsr_next(input logic [31:0] l);
		return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
	endfunction

	function automatic int mag(input logic signed [7:0] o);
		return (o < 0) ? -int'(o) : int'(o);
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge ref_clk);
		req.rd <= 1'b0;
		@(negedge ref_clk);
		d = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string m);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp, m);
	endtask

	// Polls the bucket level until it equals lvl, bounded
	task automatic wait_lvl(input logic [7:0] lvl);
		logic [7:0] d;
		d = 8'hFF;
		for (int i = 0; i < 600 && d !== lvl; i++)
			rd(ADDR_BUCKET_LVL, d);
		chk(d, lvl, "bucket level wait");
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge ref_clk);
		err_count++;
		wrap_up();
	end

	initial begin
		logic [7:0] ra [11] = '{ADDR_SOFT_LIMIT, ADDR_RAISE_THR, ADDR_LOWER_THR,
			ADDR_BUCKET_SIZE, ADDR_DECAY_RATE, ADDR_HARD_LIMIT, ADDR_STATUS, ADDR_MASK,
			ADDR_BUCKET_LVL, 8'h70, 8'h00};
		logic [7:0] re [11] = '{RST_SOFT_LIMIT, RST_RAISE_THR, RST_LOWER_THR,
			RST_BUCKET_SIZE, RST_DECAY_RATE, RST_HARD_LIMIT, 8'h00, RST_MASK,
			8'h00, 8'h00, 8'h00};
		ref_clk = 1'b0;
		reset_n = 1'b0;
		req = '0;
		{off0, off1, raw0, raw1, fault} = '0;
		err_count = 0;
		checks = 0;
		lfsr_q = 32'hF554;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 11; i++)
			rchk(ra[i], re[i], "reset value");
		chk(irq, 1'b0, "irq after reset");
		wr(ADDR_MASK, 8'hFF);
		rchk(ADDR_MASK, 8'h3F, "mask width");
		wr(ADDR_BUCKET_LVL, 8'h55);
		rchk(ADDR_BUCKET_LVL, 8'h00, "level read only");
		// Random offsets against a small soft limit and a hard limit, option off then on
		for (int en = 0; en < 2; en++) begin
			wr(ADDR_SOFT_LIMIT, {en[0], 7'h14});
			wr(ADDR_HARD_LIMIT, 8'h3C);
			for (int i = 0; i < 60; i++) begin
				lfsr_q = lfsr_next(lfsr_q);
				@(posedge ref_clk);
				off0 <= (i == 0) ? -8'sd21 : (i == 1) ? 8'sd20 : lfsr_q[7:0];
				off1 <= (i == 0) ? 8'sd21 : (i == 1) ? -8'sd20 : lfsr_q[15:8];
				raw0 <= lfsr_q[16] & lfsr_q[17];
				raw1 <= lfsr_q[18] & lfsr_q[19];
				@(posedge ref_clk);
				@(negedge ref_clk);
				chk(soft_status, {2'b00, mag(off1) > 20, mag(off0) > 20, 4'h0}, "soft");
				chk(pll_flags.soft_alarm0, mag(off0) > 20, "soft flag 0");
				chk(pll_flags.soft_alarm1, mag(off1) > 20, "soft flag 1");
				chk(pll_flags.phase_lost0, raw0 | (en == 1 && mag(off0) >= 60), "ph0");
				chk(pll_flags.phase_lost1, raw1 | (en == 1 && mag(off1) >= 60), "ph1");
			end
		end
		@(posedge ref_clk);
		{off0, off1, raw0, raw1} <= '0;
		wr(ADDR_STATUS, 8'hFF);
		wr(ADDR_MASK, 8'h10);
		@(negedge ref_clk);
		chk(irq, 1'b0, "irq after clear");
		// Bucket fills, raises, saturates at size, drains, clears and stops at zero
		@(posedge ref_clk);
		fault <= 1'b1;
		for (int i = 0; i < 400 && inactivity_alarm !== 1'b1; i++)
			@(negedge ref_clk);
		chk(inactivity_alarm, 1'b1, "alarm raised");
		rchk(ADDR_BUCKET_LVL, RST_RAISE_THR, "level at raise");
		chk(irq, 1'b1, "irq on raise");
		wr(ADDR_STATUS, 8'h10);
		@(negedge ref_clk);
		chk(irq, 1'b0, "irq after w1c");
		repeat (12 * CYC) @(posedge ref_clk);
		rchk(ADDR_BUCKET_LVL, RST_BUCKET_SIZE, "level capped");
		@(posedge ref_clk);
		fault <= 1'b0;
		for (int i = 0; i < 400 && inactivity_alarm !== 1'b0; i++)
			@(negedge ref_clk);
		chk(inactivity_alarm, 1'b0, "alarm cleared");
		rchk(ADDR_BUCKET_LVL, RST_LOWER_THR, "level at clear");
		chk(irq, 1'b0, "masked clear event");
		repeat (12 * CYC) @(posedge ref_clk);
		rchk(ADDR_BUCKET_LVL, 8'h00, "level floor");
		// Decay period for each rate setting
		for (int d = 0; d < 4; d++) begin
			wr(ADDR_DECAY_RATE, d[7:0]);
			fault <= 1'b1;
			repeat (12 * CYC) @(posedge ref_clk);
			fault <= 1'b0;
			wait_lvl(8'h07);
			t0 = int'($time);
			wait_lvl(8'h06);
			dt = (int'($time) - t0) / 50 - (1 << d) * CYC;
			chk(dt >= -4 && dt <= 4, 1'b1, "decay period");
		end
		// Shrinking the bucket clips the count at once
		wr(ADDR_BUCKET_SIZE, 8'h03);
		rchk(ADDR_BUCKET_LVL, 8'h03, "level clipped");
		// Random write and read back of every writable register except status and mask
		for (int i = 0; i < 6; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			v = lfsr_q[7:0];
			wr(ra[i], v);
			rchk(ra[i], (ra[i] == ADDR_DECAY_RATE) ? {6'h00, v[1:0]} : v, "readback");
		end
		wrap_up();
	end
endmodule // testbench
